// ===== shared/bas_pkg.sv
// Shared constants and types for the BCD and binary add and subtract datapath.
package bas_pkg;
	// Byte offsets of the registers on the bus.
	localparam logic [7:0] OFS_ACC_A = 8'h00;
	localparam logic [7:0] OFS_ACC_B = 8'h04;
	localparam logic [7:0] OFS_OPERAND = 8'h08;
	localparam logic [7:0] OFS_INDEX = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_COMMAND = 8'h14;
	localparam logic [7:0] OFS_EFF_ADDR = 8'h18;
	localparam logic [7:0] OFS_STORE = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// Field positions inside the status register.
	localparam int STS_TAKEN_BIT = 0;
	localparam int STS_KNOWN_BIT = 1;

	// Instruction encodings.
	localparam logic [7:0] OPC_ACC_SUM = 8'h1B;
	localparam logic [7:0] OPC_ADD_CARRY_IDX = 8'hA9;
	localparam logic [7:0] OPC_MINUS_IDX = 8'hA0;
	localparam logic [7:0] OPC_MINUS_BORROW_IDX = 8'hA2;
	localparam logic [7:0] OPC_DEC_ADJ = 8'h19;
	localparam logic [7:0] OPC_FORCE_CARRY = 8'h0D;
	localparam logic [7:0] OPC_INDEX_DEC = 8'h09;
	localparam logic [7:0] OPC_BRANCH_NZ = 8'h26;
	localparam logic [7:0] OPC_LOAD_IDX = 8'hA6;
	localparam logic [7:0] OPC_STORE_IDX = 8'hA7;
	localparam logic [7:0] OPC_LOAD_INDEX_IMM = 8'hCE;

	// Values after reset.
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_INDEX = 16'h0000;
	localparam logic [5:0] RST_FLAGS = 6'h00;

	// Decimal adjust correction constants and the largest BCD digit.
	localparam logic [7:0] ADJ_ADD_NONE = 8'h00;
	localparam logic [7:0] ADJ_ADD_LO = 8'h06;
	localparam logic [7:0] ADJ_ADD_HI = 8'h60;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] BCD_HI_SPLIT = 4'h8;

	// Condition code bits, half-carry in bit 5 down to carry in bit 0.
	typedef struct packed {
		logic h;
		logic i;
		logic n;
		logic z;
		logic v;
		logic c;
	} bas_ccr_t;

	// Command word: opcode low, offset next, upper immediate byte above.
	typedef struct packed {
		logic [7:0] imm_hi;
		logic [7:0] offset;
		logic [7:0] opcode;
	} bas_cmd_t;

	// Accumulator value together with the flags it produces.
	typedef struct packed {
		logic [7:0] acc;
		bas_ccr_t ccr;
	} bas_res_t;
endpackage : bas_pkg

// ===== rtl/bas_bcd_alu.sv
// Accumulator add, subtract and decimal adjust datapath behind an AHB-Lite slave.
//
// Functional notes
// - Carry-set adjust adds 60 or 66, carry stays.
// - Adjust adds 00, 06, 60 or 66.
// - Adjust covers all BCD sum cases.
// - Adjust sets negative and zero from result.
// - Adjust keeps half-carry and mask; overflow free.
// - Adjust carry equals true decimal carry.
// - Accumulator sum adds second into first.
// - Add with carry adds operand plus carry.
// - Addition overflow and carry from sign bits.
// - Subtract sets borrow when operand exceeds accumulator.
// - Subtract with borrow removes operand and carry.
// - Subtraction overflow and borrow from sign bits.
// - Loads, stores, decrement, branch keep carry.
// - Opcode 0D forces carry only.
// - Opcode A9 adds with carry, indexed.
// - Opcode A0 subtracts, indexed.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module bas_bcd_alu (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	logic wr_ff;
	logic rd_pend_ff;
	logic [7:0] addr_ff;
	logic [31:0] hrdata_ff;
	logic [7:0] acc_a_ff;
	logic [7:0] acc_b_ff;
	logic [7:0] operand_ff;
	logic [15:0] index_ff;
	bas_pkg::bas_ccr_t ccr_ff;
	logic [7:0] last_op_ff;
	logic [15:0] eff_addr_ff;
	logic [7:0] store_ff;
	logic taken_ff;
	logic known_ff;
	logic accept;
	logic do_exec;
	bas_pkg::bas_cmd_t cmd;
	logic [15:0] idx_addr;
	logic [7:0] nxt_acc_a;
	bas_pkg::bas_ccr_t nxt_ccr;
	logic [15:0] nxt_index;
	logic [7:0] nxt_store;
	logic nxt_taken;
	logic nxt_known;
	logic nxt_idx_op;
	logic [7:0] adj_add;
	logic adj_lo;
	logic adj_hi;
	logic [7:0] adj_sum;
	logic [15:0] dec_index;
	bas_pkg::bas_res_t alu_res;

	// Binary addition with carry in; half-carry from the low nibbles, carry from the ninth sum bit.
	function automatic bas_pkg::bas_res_t bas_add(input logic [7:0] a, input logic [7:0] m,
		input logic cin, input bas_pkg::bas_ccr_t f);
		logic [8:0] s;
		logic [4:0] hs;
		bas_pkg::bas_res_t r;
		s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
		hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
		r.acc = s[7:0];
		r.ccr = f;
		r.ccr.h = hs[4];
		r.ccr.n = s[7];
		r.ccr.z = (s[7:0] == 8'h00);
		r.ccr.v = (a[7] == m[7]) && (s[7] != a[7]);
		r.ccr.c = s[8];
		return r;
	endfunction : bas_add

	// Binary subtraction with borrow in; half-carry is left alone.
	function automatic bas_pkg::bas_res_t bas_sub(input logic [7:0] a, input logic [7:0] m,
		input logic bin, input bas_pkg::bas_ccr_t f);
		logic [8:0] s;
		bas_pkg::bas_res_t r;
		s = {1'b0, a} - {1'b0, m} - {8'h00, bin};
		r.acc = s[7:0];
		r.ccr = f;
		r.ccr.n = s[7];
		r.ccr.z = (s[7:0] == 8'h00);
		r.ccr.v = (a[7] != m[7]) && (s[7] != a[7]);
		r.ccr.c = s[8];
		return r;
	endfunction : bas_sub

	// Read multiplexer over the register map; unmapped offsets read as zero.
	function automatic logic [31:0] bas_read(input logic [7:0] ofs, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] m, input logic [15:0] x,
		input bas_pkg::bas_ccr_t f, input logic [7:0] op, input logic [15:0] ea,
		input logic [7:0] st, input logic tk, input logic kn);
		logic [31:0] d;
		d = 32'h0000_0000;
		case (ofs)
			bas_pkg::OFS_ACC_A: d = {24'h00_0000, a};
			bas_pkg::OFS_ACC_B: d = {24'h00_0000, b};
			bas_pkg::OFS_OPERAND: d = {24'h00_0000, m};
			bas_pkg::OFS_INDEX: d = {16'h0000, x};
			bas_pkg::OFS_FLAGS: d = {26'h000_0000, f};
			bas_pkg::OFS_COMMAND: d = {24'h00_0000, op};
			bas_pkg::OFS_EFF_ADDR: d = {16'h0000, ea};
			bas_pkg::OFS_STORE: d = {24'h00_0000, st};
			bas_pkg::OFS_STATUS: d = {30'h0000_0000, kn, tk};
			default: d = 32'h0000_0000;
		endcase
		return d;
	endfunction : bas_read

	// Bus handshake: writes finish at once, reads take one wait state.
	assign accept = hsel && hready && htrans[1];
	assign hreadyout = !rd_pend_ff;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign do_exec = wr_ff && (addr_ff == bas_pkg::OFS_COMMAND);
	assign cmd = bas_pkg::bas_cmd_t'(hwdata[23:0]);
	assign idx_addr = index_ff + {8'h00, cmd.offset};
	assign dec_index = index_ff - 16'h0001;

	// Address phase capture.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else if (hready) begin
			wr_ff <= accept && hwrite;
			rd_pend_ff <= accept && !hwrite;
			addr_ff <= haddr[7:0];
		end else begin
			rd_pend_ff <= 1'b0;
		end
	end

	// Read data is taken in the wait state, after any earlier write has landed.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (rd_pend_ff) begin
			hrdata_ff <= bas_read(addr_ff, acc_a_ff, acc_b_ff, operand_ff, index_ff, ccr_ff,
				last_op_ff, eff_addr_ff, store_ff, taken_ff, known_ff);
		end
	end

	// Decimal adjust correction, chosen from carry, both digits and half-carry.
	always_comb begin
		adj_lo = ccr_ff.h || (acc_a_ff[3:0] > bas_pkg::BCD_MAX_DIGIT);
		adj_hi = ccr_ff.c || (acc_a_ff[7:4] > bas_pkg::BCD_MAX_DIGIT)
			|| ((acc_a_ff[7:4] > bas_pkg::BCD_HI_SPLIT)
			&& (acc_a_ff[3:0] > bas_pkg::BCD_MAX_DIGIT));
		adj_add = (adj_hi ? bas_pkg::ADJ_ADD_HI : bas_pkg::ADJ_ADD_NONE)
			| (adj_lo ? bas_pkg::ADJ_ADD_LO : bas_pkg::ADJ_ADD_NONE);
		adj_sum = acc_a_ff + adj_add;
	end

	// Instruction execution on a write of the command register.
	always_comb begin
		nxt_acc_a = acc_a_ff;
		nxt_ccr = ccr_ff;
		nxt_index = index_ff;
		nxt_store = store_ff;
		nxt_taken = taken_ff;
		nxt_known = 1'b1;
		nxt_idx_op = 1'b0;
		alu_res = {acc_a_ff, ccr_ff};
		case (cmd.opcode)
			bas_pkg::OPC_ACC_SUM: begin
				alu_res = bas_add(acc_a_ff, acc_b_ff, 1'b0, ccr_ff);
				nxt_acc_a = alu_res.acc;
				nxt_ccr = alu_res.ccr;
			end
			bas_pkg::OPC_ADD_CARRY_IDX: begin
				alu_res = bas_add(acc_a_ff, operand_ff, ccr_ff.c, ccr_ff);
				nxt_acc_a = alu_res.acc;
				nxt_ccr = alu_res.ccr;
				nxt_idx_op = 1'b1;
			end
			bas_pkg::OPC_MINUS_IDX: begin
				alu_res = bas_sub(acc_a_ff, operand_ff, 1'b0, ccr_ff);
				nxt_acc_a = alu_res.acc;
				nxt_ccr = alu_res.ccr;
				nxt_idx_op = 1'b1;
			end
			bas_pkg::OPC_MINUS_BORROW_IDX: begin
				alu_res = bas_sub(acc_a_ff, operand_ff, ccr_ff.c, ccr_ff);
				nxt_acc_a = alu_res.acc;
				nxt_ccr = alu_res.ccr;
				nxt_idx_op = 1'b1;
			end
			bas_pkg::OPC_DEC_ADJ: begin
				// Half-carry, mask and overflow are left as they were.
				nxt_acc_a = adj_sum;
				nxt_ccr.n = adj_sum[7];
				nxt_ccr.z = (adj_sum == 8'h00);
				nxt_ccr.c = adj_hi;
			end
			bas_pkg::OPC_FORCE_CARRY: begin
				nxt_ccr.c = 1'b1;
			end
			bas_pkg::OPC_INDEX_DEC: begin
				nxt_index = dec_index;
				nxt_ccr.z = (dec_index == 16'h0000);
			end
			bas_pkg::OPC_BRANCH_NZ: begin
				nxt_taken = !ccr_ff.z;
			end
			bas_pkg::OPC_LOAD_IDX: begin
				nxt_acc_a = operand_ff;
				nxt_ccr.n = operand_ff[7];
				nxt_ccr.z = (operand_ff == 8'h00);
				nxt_ccr.v = 1'b0;
				nxt_idx_op = 1'b1;
			end
			bas_pkg::OPC_STORE_IDX: begin
				nxt_store = acc_a_ff;
				nxt_ccr.n = acc_a_ff[7];
				nxt_ccr.z = (acc_a_ff == 8'h00);
				nxt_ccr.v = 1'b0;
				nxt_idx_op = 1'b1;
			end
			bas_pkg::OPC_LOAD_INDEX_IMM: begin
				nxt_index = {cmd.imm_hi, cmd.offset};
				nxt_ccr.n = cmd.imm_hi[7];
				nxt_ccr.z = ({cmd.imm_hi, cmd.offset} == 16'h0000);
				nxt_ccr.v = 1'b0;
			end
			default: begin
				nxt_known = 1'b0;
			end
		endcase
	end

	// Accumulators and memory operand, written by software or by execution.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_a_ff <= bas_pkg::RST_BYTE;
			acc_b_ff <= bas_pkg::RST_BYTE;
			operand_ff <= bas_pkg::RST_BYTE;
		end else if (do_exec) begin
			acc_a_ff <= nxt_acc_a;
		end else if (wr_ff) begin
			if (addr_ff == bas_pkg::OFS_ACC_A) acc_a_ff <= hwdata[7:0];
			if (addr_ff == bas_pkg::OFS_ACC_B) acc_b_ff <= hwdata[7:0];
			if (addr_ff == bas_pkg::OFS_OPERAND) operand_ff <= hwdata[7:0];
		end
	end

	// Index register and condition codes.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index_ff <= bas_pkg::RST_INDEX;
			ccr_ff <= bas_pkg::RST_FLAGS;
		end else if (do_exec) begin
			index_ff <= nxt_index;
			ccr_ff <= nxt_ccr;
		end else if (wr_ff) begin
			if (addr_ff == bas_pkg::OFS_INDEX) index_ff <= hwdata[15:0];
			if (addr_ff == bas_pkg::OFS_FLAGS) ccr_ff <= bas_pkg::bas_ccr_t'(hwdata[5:0]);
		end
	end

	// Execution results: last opcode, operand address, stored byte and status.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_op_ff <= bas_pkg::RST_BYTE;
			eff_addr_ff <= bas_pkg::RST_INDEX;
			store_ff <= bas_pkg::RST_BYTE;
			taken_ff <= 1'b0;
			known_ff <= 1'b0;
		end else if (do_exec) begin
			last_op_ff <= cmd.opcode;
			store_ff <= nxt_store;
			taken_ff <= nxt_taken;
			known_ff <= nxt_known;
			if (nxt_idx_op) eff_addr_ff <= idx_addr;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	acc_sum_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_ACC_SUM |=>
		acc_a_ff == 8'($past(acc_a_ff) + $past(acc_b_ff))
		&& ccr_ff.c == ({1'b0, $past(acc_a_ff)} + {1'b0, $past(acc_b_ff)} > 9'h0FF))
		else $error("accumulator sum wrong");
	adc_result_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_ADD_CARRY_IDX |=>
		acc_a_ff == 8'($past(acc_a_ff) + $past(operand_ff) + {7'h00, $past(ccr_ff.c)})
		&& eff_addr_ff == 16'($past(index_ff) + {8'h00, $past(hwdata[15:8])}))
		else $error("add with carry result or address wrong");
	add_flags_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_ADD_CARRY_IDX |=>
		ccr_ff.v == (($past(acc_a_ff[7]) == $past(operand_ff[7])) && acc_a_ff[7] != $past(acc_a_ff[7]))
		&& ccr_ff.c == (($past(acc_a_ff[7]) && $past(operand_ff[7]))
		|| (($past(acc_a_ff[7]) ^ $past(operand_ff[7])) && !acc_a_ff[7])))
		else $error("addition flags wrong");
	sub_borrow_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_MINUS_IDX |=>
		ccr_ff.c == ($past(operand_ff) > $past(acc_a_ff))
		&& acc_a_ff == 8'($past(acc_a_ff) - $past(operand_ff)))
		else $error("subtract borrow wrong");
	sub_flags_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_MINUS_BORROW_IDX |=>
		ccr_ff.v == (($past(acc_a_ff[7]) != $past(operand_ff[7])) && acc_a_ff[7] != $past(acc_a_ff[7])))
		else $error("subtraction overflow wrong");
	adj_keep_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_DEC_ADJ |=>
		$stable(ccr_ff.h) && $stable(ccr_ff.i) && ccr_ff.n == acc_a_ff[7]
		&& ccr_ff.z == (acc_a_ff == 8'h00))
		else $error("decimal adjust flag handling wrong");
	adj_carry_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_DEC_ADJ && ccr_ff.c
		&& !ccr_ff.h && acc_a_ff[7:4] <= 4'h2 && acc_a_ff[3:0] <= 4'h9 |=>
		acc_a_ff == 8'($past(acc_a_ff) + 8'h60) && ccr_ff.c)
		else $error("decimal adjust with carry wrong");
	carry_force_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_FORCE_CARRY |=>
		ccr_ff.c && $stable(acc_a_ff) && $stable(acc_b_ff) && $stable(ccr_ff[5:1]))
		else $error("force carry wrong");
	carry_keep_a: assert property (do_exec && (cmd.opcode == bas_pkg::OPC_LOAD_IDX
		|| cmd.opcode == bas_pkg::OPC_STORE_IDX || cmd.opcode == bas_pkg::OPC_INDEX_DEC
		|| cmd.opcode == bas_pkg::OPC_BRANCH_NZ) |=> $stable(ccr_ff.c))
		else $error("carry disturbed");
	index_dec_a: assert property (do_exec && cmd.opcode == bas_pkg::OPC_INDEX_DEC |=>
		index_ff == 16'($past(index_ff) - 16'h0001) && ccr_ff.z == (index_ff == 16'h0000))
		else $error("index decrement wrong");
	read_wait_a: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
endmodule : bas_bcd_alu

// ===== verification/bas_bcd_alu_tb_top.sv
// Self-checking testbench for the add, subtract and decimal adjust datapath.
`timescale 1ns/1ps
module bas_bcd_alu_tb_top;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] m;
		logic [5:0] fin;
		logic [7:0] aexp;
		logic [5:0] fexp;
	} bas_row_t;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	// Columns: opcode, first, second, operand, flags in, first out, flags out.
	bas_row_t rows [0:18] = '{
		'{8'h1B, 8'hAA, 8'hCC, 8'h00, 6'h00, 8'h76, 6'h23},
		'{8'h1B, 8'h80, 8'h80, 8'h00, 6'h00, 8'h00, 6'h07},
		'{8'hA9, 8'hAA, 8'h00, 8'hCC, 6'h01, 8'h77, 6'h23},
		'{8'hA9, 8'h0F, 8'h00, 8'h00, 6'h01, 8'h10, 6'h20},
		'{8'hA0, 8'h65, 8'h00, 8'h87, 6'h00, 8'hDE, 6'h0B},
		'{8'hA2, 8'h10, 8'h00, 8'h05, 6'h11, 8'h0A, 6'h10},
		'{8'hA2, 8'h00, 8'h00, 8'hFF, 6'h01, 8'h00, 6'h05},
		'{8'h19, 8'hE0, 8'h00, 8'h00, 6'h20, 8'h46, 6'h21},
		'{8'h19, 8'h15, 8'h00, 8'h00, 6'h01, 8'h75, 6'h01},
		'{8'h19, 8'h2A, 8'h00, 8'h00, 6'h01, 8'h90, 6'h09},
		'{8'h19, 8'h33, 8'h00, 8'h00, 6'h21, 8'h99, 6'h29},
		'{8'h19, 8'h9A, 8'h00, 8'h00, 6'h00, 8'h00, 6'h05},
		'{8'h19, 8'h45, 8'h00, 8'h00, 6'h10, 8'h45, 6'h10},
		'{8'h19, 8'h8C, 8'h00, 8'h00, 6'h00, 8'h92, 6'h08},
		'{8'h19, 8'h92, 8'h00, 8'h00, 6'h20, 8'h98, 6'h28},
		'{8'h19, 8'hB3, 8'h00, 8'h00, 6'h00, 8'h13, 6'h01},
		'{8'h19, 8'hA1, 8'h00, 8'h00, 6'h20, 8'h07, 6'h21},
		'{8'h0D, 8'h55, 8'h00, 8'h00, 6'h14, 8'h55, 6'h15},
		'{8'hFF, 8'h33, 8'h00, 8'h00, 6'h2A, 8'h33, 6'h2A}
	};

	// The single slave's ready is fed back as the bus ready.
	bas_bcd_alu dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(1'b1),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'b010),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp)
	);

	// Free-running clock at 200 MHz.
	always #2.5 hclk = ~hclk;

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// Cuts a hang short by counting it as a mismatch.
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 5000) begin
			n_fail++;
			$display("ERROR %0t run timed out", $time);
			end_sim();
		end
	end

	// Waits for an edge at which ready is sampled high, within a bound.
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 64) begin
			n_fail++;
			$display("ERROR %0t ready never came", $time);
		end
	endtask : wait_ready

	// One single word write; entered just after a rising edge.
	task automatic bus_write(input logic [7:0] ofs, input logic [31:0] data);
		haddr <= {24'h000000, ofs};
		hwrite <= 1'b1;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= data;
		wait_ready();
	endtask : bus_write

	// One single word read; data is taken at the edge that ends the data phase.
	task automatic bus_read(input logic [7:0] ofs, output logic [31:0] data);
		haddr <= {24'h000000, ofs};
		hwrite <= 1'b0;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		wait_ready();
		data = hrdata;
	endtask : bus_read

	// Reads a register and compares it with the expected word.
	task automatic chk_reg(input logic [7:0] ofs, input logic [31:0] exp);
		logic [31:0] got;
		bus_read(ofs, got);
		n_compared++;
		if (got !== exp || hresp !== 1'b0) begin
			n_fail++;
			$display("ERROR %0t offset %h got %h expected %h", $time, ofs, got, exp);
		end
	endtask : chk_reg

	// Writes a command word of opcode, offset and upper immediate byte.
	task automatic exec(input logic [7:0] op, input logic [7:0] off, input logic [7:0] hi);
		bus_write(bas_pkg::OFS_COMMAND, {8'h00, hi, off, op});
	endtask : exec

	// Main sequence: table rows first, then the hand-written cases.
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus_write(bas_pkg::OFS_ACC_A, {24'h000000, rows[i].a});
			bus_write(bas_pkg::OFS_ACC_B, {24'h000000, rows[i].b});
			bus_write(bas_pkg::OFS_OPERAND, {24'h000000, rows[i].m});
			bus_write(bas_pkg::OFS_FLAGS, {26'h0000000, rows[i].fin});
			exec(rows[i].op, 8'h00, 8'h00);
			chk_reg(bas_pkg::OFS_ACC_A, {24'h000000, rows[i].aexp});
			chk_reg(bas_pkg::OFS_FLAGS, {26'h0000000, rows[i].fexp});
		end
		// Index countdown with branch decisions, carry held throughout.
		bus_write(bas_pkg::OFS_INDEX, 32'h00000002);
		bus_write(bas_pkg::OFS_FLAGS, 32'h00000001);
		exec(bas_pkg::OPC_INDEX_DEC, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_INDEX, 32'h00000001);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000001);
		exec(bas_pkg::OPC_BRANCH_NZ, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_STATUS, 32'h00000003);
		exec(bas_pkg::OPC_INDEX_DEC, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000005);
		exec(bas_pkg::OPC_BRANCH_NZ, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_STATUS, 32'h00000002);
		// Indexed store and load keep carry.
		bus_write(bas_pkg::OFS_ACC_A, 32'h00000080);
		bus_write(bas_pkg::OFS_INDEX, 32'h00000100);
		exec(bas_pkg::OPC_STORE_IDX, 8'h03, 8'h00);
		chk_reg(bas_pkg::OFS_STORE, 32'h00000080);
		chk_reg(bas_pkg::OFS_EFF_ADDR, 32'h00000103);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000009);
		bus_write(bas_pkg::OFS_OPERAND, 32'h00000000);
		exec(bas_pkg::OPC_LOAD_IDX, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000005);
		exec(bas_pkg::OPC_LOAD_INDEX_IMM, 8'h34, 8'h12);
		chk_reg(bas_pkg::OFS_INDEX, 32'h00001234);
		// Decimal 99 plus 01 plus carry gives 01 with decimal carry out.
		bus_write(bas_pkg::OFS_INDEX, 32'h00000010);
		bus_write(bas_pkg::OFS_ACC_A, 32'h00000099);
		bus_write(bas_pkg::OFS_OPERAND, 32'h00000001);
		bus_write(bas_pkg::OFS_FLAGS, 32'h00000001);
		exec(bas_pkg::OPC_ADD_CARRY_IDX, 8'h05, 8'h00);
		chk_reg(bas_pkg::OFS_EFF_ADDR, 32'h00000015);
		exec(bas_pkg::OPC_DEC_ADJ, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_ACC_A, 32'h00000001);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000001);
		exec(bas_pkg::OPC_MINUS_IDX, 8'hFF, 8'h00);
		chk_reg(bas_pkg::OFS_EFF_ADDR, 32'h0000010F);
		// Unmapped place ignores writes and reads zero.
		bus_write(8'h24, 32'hFFFFFFFF);
		chk_reg(8'h24, 32'h00000000);
		// An unknown opcode clears the known bit and leaves the branch decision alone.
		exec(8'hFF, 8'h00, 8'h00);
		chk_reg(bas_pkg::OFS_STATUS, 32'h00000000);
		// A second reset in mid-run clears the registers.
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_reg(bas_pkg::OFS_ACC_A, 32'h00000000);
		chk_reg(bas_pkg::OFS_FLAGS, 32'h00000000);
		chk_reg(bas_pkg::OFS_INDEX, 32'h00000000);
		end_sim();
	end
endmodule : bas_bcd_alu_tb_top
